// ===== logic/crank_sync_pkg.sv
`default_nettype none
package crank_sync_pkg;

  localparam int unsigned NUM_CRANK = 2;
  localparam int unsigned NUM_BP = 2;
  localparam int unsigned NUM_SLOTS = 6;
  localparam int unsigned NUM_SYNC = 6;

  // source select encodings shared by crank buses and sync lines
  localparam logic [7:0] SRC_NONE = 8'h00;
  localparam logic [7:0] SRC_BP0 = 8'h01;
  localparam logic [7:0] SRC_BP1 = 8'h02;
  localparam logic [7:0] SRC_SW = 8'h03;
  localparam logic [7:0] SRC_SLOT0 = 8'h04;
  localparam logic [7:0] SRC_SLOT_LAST = 8'h09;

  // reset values
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [5:0] LEVEL_RESET = 6'h00;

  // register byte offsets
  localparam logic [7:0] OFS_CRANK0_SEL = 8'h00;
  localparam logic [7:0] OFS_CRANK1_SEL = 8'h04;
  localparam logic [7:0] OFS_SYNC_SEL0 = 8'h08;
  localparam logic [7:0] OFS_STRIDE = 8'h04;
  localparam logic [7:0] OFS_SW_LEVEL = 8'h20;
  localparam logic [7:0] OFS_SYNC_STAT = 8'h24;
  localparam logic [7:0] OFS_CRANK_STAT = 8'h28;
  localparam logic [7:0] OFS_SEL_ERR = 8'h2c;

  // field positions
  localparam int unsigned CRANK_STAT_BUS1_POS = 4;
  localparam int unsigned CRANK_STAT_OE_POS = 8;
  localparam int unsigned SYNC_STAT_OE_POS = 8;
  localparam int unsigned SEL_ERR_SYNC_POS = 8;

  // one crank-angle-clock bus: zero mark, angle clock, direction
  typedef struct packed {
    logic dir;
    logic angle;
    logic zero;
  } crank_s;

endpackage
`default_nettype wire

// ===== logic/input_sync.sv
`timescale 1ns/1ps
`default_nettype none
module input_sync
  import crank_sync_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q, meta_d;
  logic [W-1:0] stable_q, stable_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = async_i;
    stable_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign sync_o = stable_q;

endmodule // input_sync
`default_nettype wire

// ===== logic/source_pick.sv
`timescale 1ns/1ps
`default_nettype none
module source_pick
  import crank_sync_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter bit ALLOW_SW = 1'b0
) (
  input wire logic [7:0] sel_i,
  input wire logic [NUM_BP-1:0][W-1:0] bp_i,
  input wire logic [NUM_SLOTS-1:0][W-1:0] slot_i,
  input wire logic [W-1:0] sw_i,
  output logic [W-1:0] val_o,
  output logic en_o,
  output logic bad_o
);

  logic [7:0] slot_idx;

  // exactly one source or none; illegal codes leave the line undriven
  always_comb begin
    val_o = '0;
    en_o = 1'b0;
    bad_o = 1'b0;
    slot_idx = 8'(sel_i - SRC_SLOT0);
    if (sel_i == SRC_BP0) begin
      en_o = 1'b1;
      val_o = bp_i[0];
    end else if (sel_i == SRC_BP1) begin
      en_o = 1'b1;
      val_o = bp_i[1];
    end else if (sel_i == SRC_SW) begin
      if (ALLOW_SW) begin
        en_o = 1'b1;
        val_o = sw_i;
      end else begin
        bad_o = 1'b1;
      end
    end else if (sel_i >= SRC_SLOT0 && sel_i <= SRC_SLOT_LAST) begin
      en_o = 1'b1;
      val_o = slot_i[slot_idx[2:0]];
    end else if (sel_i != SRC_NONE) begin
      bad_o = 1'b1;
    end
  end

endmodule // source_pick
`default_nettype wire

// ===== logic/crank_sync_bus_router.sv
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module crank_sync_bus_router
  import crank_sync_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire crank_s [NUM_BP-1:0] bp_crank_i,
  input wire crank_s [NUM_SLOTS-1:0] slot_crank_i,
  input wire logic [NUM_BP-1:0] bp_sync_i,
  input wire logic [NUM_SLOTS-1:0][NUM_SYNC-1:0] slot_sync_i,
  output crank_s [NUM_CRANK-1:0] crank_bus_o,
  output logic [NUM_CRANK-1:0] crank_bus_oe_o,
  output logic [NUM_SYNC-1:0] sync_line_o,
  output logic [NUM_SYNC-1:0] sync_line_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs through two flops

  // one synchroniser for all pins: equal delay keeps a crank bus's lines aligned
  localparam int unsigned BP_CRANK_W = NUM_BP * 3;
  localparam int unsigned SLOT_CRANK_W = NUM_SLOTS * 3;
  localparam int unsigned SLOT_SYNC_W = NUM_SLOTS * NUM_SYNC;
  localparam int unsigned PIN_W = BP_CRANK_W + SLOT_CRANK_W + NUM_BP + SLOT_SYNC_W;

  logic [PIN_W-1:0] pins_async;
  logic [PIN_W-1:0] pins_sync;
  crank_s [NUM_BP-1:0] bp_crank_s;
  crank_s [NUM_SLOTS-1:0] slot_crank_s;
  logic [NUM_BP-1:0] bp_sync_s;
  logic [NUM_SLOTS-1:0][NUM_SYNC-1:0] slot_sync_s;

  assign pins_async = {bp_crank_i, slot_crank_i, bp_sync_i, slot_sync_i};
  assign {bp_crank_s, slot_crank_s, bp_sync_s, slot_sync_s} = pins_sync;

  input_sync #(
    .W(PIN_W)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register address decode, shared by the write and read paths

  logic hit_crank0;
  logic hit_crank1;
  logic [NUM_SYNC-1:0] hit_sync_sel;
  logic hit_sw_level;
  logic hit_sync_stat;
  logic hit_crank_stat;
  logic hit_sel_err;

  for (genvar i = 0; i < NUM_SYNC; i++) begin : g_hit
    assign hit_sync_sel[i] = (wb_adr_i == 8'(OFS_SYNC_SEL0 + 8'(8'(i) * OFS_STRIDE)));
  end

  // one decode so read-back can never drift from the write map
  always_comb begin
    hit_crank0 = (wb_adr_i == OFS_CRANK0_SEL);
    hit_crank1 = (wb_adr_i == OFS_CRANK1_SEL);
    hit_sw_level = (wb_adr_i == OFS_SW_LEVEL);
    hit_sync_stat = (wb_adr_i == OFS_SYNC_STAT);
    hit_crank_stat = (wb_adr_i == OFS_CRANK_STAT);
    hit_sel_err = (wb_adr_i == OFS_SEL_ERR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [NUM_CRANK-1:0][7:0] crank_sel_q, crank_sel_d;
  logic [NUM_SYNC-1:0][7:0] sync_sel_q, sync_sel_d;
  logic [NUM_SYNC-1:0] sw_level_q, sw_level_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic bus_req;
  logic wr_now;
  logic take;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // taken only while ack is low, so a held strobe cannot retrigger in the ack cycle
  assign take = bus_req & ~ack_q;
  // write lands on the edge where the master sees ack
  assign wr_now = bus_req & wb_we_i & ack_q & wb_sel_i[0];

  always_comb begin
    crank_sel_d = crank_sel_q;
    sync_sel_d = sync_sel_q;
    sw_level_d = sw_level_q;
    if (wr_now) begin
      if (hit_crank0) begin
        crank_sel_d[0] = wb_dat_i[7:0];
      end
      if (hit_crank1) begin
        crank_sel_d[1] = wb_dat_i[7:0];
      end
      for (int i = 0; i < NUM_SYNC; i++) begin
        if (hit_sync_sel[i]) begin
          sync_sel_d[i] = wb_dat_i[7:0];
        end
      end
      if (hit_sw_level) begin
        sw_level_d = wb_dat_i[NUM_SYNC-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crank_sel_q <= {NUM_CRANK{SEL_RESET}};
      sync_sel_q <= {NUM_SYNC{SEL_RESET}};
      sw_level_q <= LEVEL_RESET;
    end else begin
      crank_sel_q <= crank_sel_d;
      sync_sel_q <= sync_sel_d;
      sw_level_q <= sw_level_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection

  crank_s [NUM_CRANK-1:0] crank_val;
  logic [NUM_CRANK-1:0] crank_en;
  logic [NUM_CRANK-1:0] crank_bad;
  logic [NUM_SYNC-1:0] sync_val;
  logic [NUM_SYNC-1:0] sync_en;
  logic [NUM_SYNC-1:0] sync_bad;
  logic [NUM_SLOTS-1:0][2:0] slot_crank_vec;
  logic [NUM_BP-1:0][2:0] bp_crank_vec;

  assign slot_crank_vec = slot_crank_s;
  assign bp_crank_vec = bp_crank_s;

  // crank bus pick, reserved code undriven
  for (genvar c = 0; c < NUM_CRANK; c++) begin : g_crank
    source_pick #(
      .W(3),
      .ALLOW_SW(1'b0)
    ) u_pick (
      .sel_i(crank_sel_q[c]),
      .bp_i(bp_crank_vec),
      .slot_i(slot_crank_vec),
      .sw_i(3'h0),
      .val_o(crank_val[c]),
      .en_o(crank_en[c]),
      .bad_o(crank_bad[c])
    );
  end

  for (genvar s = 0; s < NUM_SYNC; s++) begin : g_sync
    logic [NUM_SLOTS-1:0] slot_line;
    for (genvar k = 0; k < NUM_SLOTS; k++) begin : g_slot
      assign slot_line[k] = slot_sync_s[k][s];
    end
    source_pick #(
      .W(1),
      .ALLOW_SW(1'b1)
    ) u_pick (
      .sel_i(sync_sel_q[s]),
      .bp_i(bp_sync_s),
      .slot_i(slot_line),
      .sw_i(sw_level_q[s]),
      .val_o(sync_val[s]),
      .en_o(sync_en[s]),
      .bad_o(sync_bad[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered line outputs

  crank_s [NUM_CRANK-1:0] crank_out_q, crank_out_d;
  logic [NUM_CRANK-1:0] crank_oe_q, crank_oe_d;
  logic [NUM_SYNC-1:0] sync_out_q, sync_out_d;
  logic [NUM_SYNC-1:0] sync_oe_q, sync_oe_d;

  // undriven lines show low so nothing floats into the slots
  always_comb begin
    for (int c = 0; c < NUM_CRANK; c++) begin
      crank_out_d[c] = crank_en[c] ? crank_val[c] : '0;
    end
    crank_oe_d = crank_en;
    sync_out_d = sync_val & sync_en;
    sync_oe_d = sync_en;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crank_out_q <= '0;
      crank_oe_q <= '0;
      sync_out_q <= '0;
      sync_oe_q <= '0;
    end else begin
      crank_out_q <= crank_out_d;
      crank_oe_q <= crank_oe_d;
      sync_out_q <= sync_out_d;
      sync_oe_q <= sync_oe_d;
    end
  end

  // same bus fans out to every slot
  assign crank_bus_o = crank_out_q;
  assign crank_bus_oe_o = crank_oe_q;
  assign sync_line_o = sync_out_q;
  assign sync_line_oe_o = sync_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after request, read data registered

  always_comb begin
    ack_d = take;
    dat_d = dat_q;
    // read word built at the take edge so it stands while ack is high
    if (take) begin
      dat_d = 32'h0000_0000;
      if (hit_crank0) begin
        dat_d[7:0] = crank_sel_q[0];
      end
      if (hit_crank1) begin
        dat_d[7:0] = crank_sel_q[1];
      end
      for (int i = 0; i < NUM_SYNC; i++) begin
        if (hit_sync_sel[i]) begin
          dat_d[7:0] = sync_sel_q[i];
        end
      end
      if (hit_sw_level) begin
        dat_d[NUM_SYNC-1:0] = sw_level_q;
      end
      if (hit_sync_stat) begin
        dat_d[NUM_SYNC-1:0] = sync_out_q;
        dat_d[SYNC_STAT_OE_POS +: NUM_SYNC] = sync_oe_q;
      end
      if (hit_crank_stat) begin
        dat_d[2:0] = crank_out_q[0];
        dat_d[CRANK_STAT_BUS1_POS +: 3] = crank_out_q[1];
        dat_d[CRANK_STAT_OE_POS +: NUM_CRANK] = crank_oe_q;
      end
      if (hit_sel_err) begin
        dat_d[NUM_CRANK-1:0] = crank_bad;
        dat_d[SEL_ERR_SYNC_POS +: NUM_SYNC] = sync_bad;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule // crank_sync_bus_router
`default_nettype wire

// ===== tb/router_chk.sv
`timescale 1ns/1ps
`default_nettype none
module router_chk
  import crank_sync_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire crank_s [NUM_BP-1:0] bp_crank_i,
  input wire crank_s [NUM_SLOTS-1:0] slot_crank_i,
  input wire logic [NUM_BP-1:0] bp_sync_i,
  input wire logic [NUM_SLOTS-1:0][NUM_SYNC-1:0] slot_sync_i,
  input wire crank_s [NUM_CRANK-1:0] crank_bus_o,
  input wire logic [NUM_CRANK-1:0] crank_bus_oe_o,
  input wire logic [NUM_SYNC-1:0] sync_line_o,
  input wire logic [NUM_SYNC-1:0] sync_line_oe_o
);
  // shadow of the selects, taken at the ack edge like the design
  logic [7:0] c0_q;
  logic [7:0] s0_q;
  logic [5:0] lv_q;
  logic wr;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  always_ff @(posedge clk_i)
    if (rst_i) c0_q <= '0; else if (wr && wb_adr_i == OFS_CRANK0_SEL) c0_q <= wb_dat_i[7:0];
  always_ff @(posedge clk_i)
    if (rst_i) s0_q <= '0; else if (wr && wb_adr_i == OFS_SYNC_SEL0) s0_q <= wb_dat_i[7:0];
  always_ff @(posedge clk_i)
    if (rst_i) lv_q <= '0; else if (wr && wb_adr_i == OFS_SW_LEVEL) lv_q <= wb_dat_i[5:0];
  ////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_reset_quiet: assert property ($fell(rst_i) |-> !crank_bus_oe_o && !sync_line_oe_o)
    else $error("line driven after reset");
  a_crank_bp_route: assert property ((c0_q == SRC_BP0) [*4] |->
    crank_bus_oe_o[0] && crank_bus_o[0] == $past(bp_crank_i[0], 3))
    else $error("crank bus not following backplane");
  a_crank_slot_route: assert property ((c0_q == SRC_SLOT_LAST) [*4] |->
    crank_bus_oe_o[0] && crank_bus_o[0] == $past(slot_crank_i[5], 3))
    else $error("crank bus not following slot");
  a_crank_rsvd_idle: assert property ((c0_q == SRC_SW) [*3] |->
    !crank_bus_oe_o[0] && crank_bus_o[0] == 3'h0)
    else $error("reserved crank select drives bus");
  a_sync_sw_level: assert property ((s0_q == SRC_SW && $stable(lv_q)) [*3] |->
    sync_line_oe_o[0] && sync_line_o[0] == lv_q[0])
    else $error("sync line not at software level");
  a_sync_none_idle: assert property ((s0_q == SRC_NONE) [*3] |->
    !sync_line_oe_o[0] && !sync_line_o[0])
    else $error("undriven sync line driven");
  a_sync_bp_route: assert property ((s0_q == SRC_BP1) [*4] |->
    sync_line_oe_o[0] && sync_line_o[0] == $past(bp_sync_i[1], 3))
    else $error("sync line not following backplane");
  a_sync_slot_route: assert property ((s0_q == SRC_SLOT0) [*4] |->
    sync_line_oe_o[0] && sync_line_o[0] == $past(slot_sync_i[0][0], 3))
    else $error("sync line not following slot");
endmodule // router_chk
`default_nettype wire

// ===== tb/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module far_side_model
  import crank_sync_pkg::*;
(
  input wire logic run_i,
  input wire logic [5:0] seed_i,
  output crank_s [NUM_BP-1:0] bp_crank_o,
  output crank_s [NUM_SLOTS-1:0] slot_crank_o,
  output logic [NUM_BP-1:0] bp_sync_o,
  output logic [NUM_SLOTS-1:0][NUM_SYNC-1:0] slot_sync_o
);
  logic lclk = 1'b0;
  // link clock parks low between runs
  always #80 lclk = run_i ? ~lclk : 1'b0;
  ////////////////////////////////////////
  // three-line crank buses
  always_comb begin
    for (int b = 0; b < NUM_BP; b++) begin
      bp_crank_o[b] = 3'(seed_i + b) ^ {1'b0, lclk, 1'b0};
      bp_sync_o[b] = seed_i[b];
    end
    // distinct code per source so a wrong pick shows
    for (int k = 0; k < NUM_SLOTS; k++) begin
      slot_crank_o[k] = 3'(seed_i + 2 + k) ^ {1'b0, lclk, 1'b0};
      for (int s = 0; s < NUM_SYNC; s++) slot_sync_o[k][s] = ~seed_i[(k + s) % 6];
    end
  end
endmodule // far_side_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import crank_sync_pkg::*;
;
  localparam logic [5:0] LV = 6'h2a;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic run = 1'b0;
  logic [5:0] seed = 6'h00;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  crank_s [NUM_BP-1:0] bp_crank_i;
  crank_s [NUM_SLOTS-1:0] slot_crank_i;
  logic [NUM_BP-1:0] bp_sync_i;
  logic [NUM_SLOTS-1:0][NUM_SYNC-1:0] slot_sync_i;
  crank_s [NUM_CRANK-1:0] crank_bus_o;
  logic [NUM_CRANK-1:0] crank_bus_oe_o;
  logic [NUM_SYNC-1:0] sync_line_o;
  logic [NUM_SYNC-1:0] sync_line_oe_o;
  int err_total = 0;
  int check_count = 0;
  int cyc_n = 0;
  crank_sync_bus_router crank_sync_bus_router_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bp_crank_i,
    .slot_crank_i, .bp_sync_i, .slot_sync_i, .crank_bus_o, .crank_bus_oe_o, .sync_line_o,
    .sync_line_oe_o);
  far_side_model far_side_model_inst (.run_i(run), .seed_i(seed), .bp_crank_o(bp_crank_i),
    .slot_crank_o(slot_crank_i), .bp_sync_o(bp_sync_i), .slot_sync_o(slot_sync_i));
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // no fixed latency assumed; the cycle ceiling ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function automatic logic [3:0] cexp(input logic [7:0] c);
    if (c == SRC_BP0 || c == SRC_BP1) return {1'b1, 3'(seed + c - 1)};
    if (c >= SRC_SLOT0 && c <= SRC_SLOT_LAST) return {1'b1, 3'(seed + c - 2)};
    return 4'h0;
  endfunction
  function automatic logic [1:0] sexp(input logic [7:0] c, input int s);
    if (c == SRC_BP0 || c == SRC_BP1) return {1'b1, seed[c - 1]};
    if (c == SRC_SW) return {1'b1, LV[s]};
    if (c >= SRC_SLOT0 && c <= SRC_SLOT_LAST) return {1'b1, ~seed[(c - 4 + s) % 6]};
    return 2'b00;
  endfunction
  ////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] r;
    chk(32'({crank_bus_oe_o, sync_line_oe_o, sync_line_o}), 32'h0);
    for (int a = 0; a <= 32; a += 4) begin
      wb_xfer(1'b0, 8'(a), 32'h0, r);
      chk(r, 32'h0);
    end
  endtask
  task automatic t_crank;
    logic [31:0] r;
    logic [7:0] c;
    logic [3:0] e0;
    logic [3:0] e1;
    for (int i = 0; i <= 10; i++) begin
      c = 8'(i);
      seed <= 6'(i * 5 + 1);
      run <= 1'b1;
      wb_xfer(1'b1, OFS_CRANK0_SEL, 32'(c), r);
      wb_xfer(1'b1, OFS_CRANK1_SEL, 32'(8'h0a - c), r);
      // live link traffic while selects change
      repeat (40) @(posedge clk_i);
      run <= 1'b0;
      // link clock parks within half a period, then three flops
      repeat (30) @(posedge clk_i);
      e0 = cexp(c);
      e1 = cexp(8'h0a - c);
      chk(32'({crank_bus_oe_o[0], crank_bus_o[0]}), 32'(e0));
      chk(32'({crank_bus_oe_o[1], crank_bus_o[1]}), 32'(e1));
      wb_xfer(1'b0, OFS_CRANK1_SEL, 32'h0, r);
      chk(r, 32'(8'h0a - c));
      wb_xfer(1'b0, OFS_SEL_ERR, 32'h0, r);
      chk(r, 32'({i < 1 || i == 7, i == 3 || i > 9}));
      wb_xfer(1'b0, OFS_CRANK_STAT, 32'h0, r);
      chk(r, 32'({e1[3], e0[3], 1'b0, e1[2:0], 1'b0, e0[2:0]}));
    end
  endtask
  task automatic t_sync;
    logic [31:0] r;
    seed <= 6'h2d;
    // a single host level update per run keeps the refresh spacing
    wb_xfer(1'b1, OFS_SW_LEVEL, 32'(LV), r);
    for (int s = 0; s < 6; s++) for (int i = 0; i <= 10; i++) begin
      wb_xfer(1'b1, OFS_SYNC_SEL0 + 8'(4 * s), 32'(i), r);
      repeat (4) @(posedge clk_i);
      chk(32'({sync_line_oe_o[s], sync_line_o[s]}), 32'(sexp(8'(i), s)));
    end
    wb_xfer(1'b0, OFS_SEL_ERR, 32'h0, r);
    chk(r, 32'h3f01);
    for (int s = 0; s < 6; s++) wb_xfer(1'b1, OFS_SYNC_SEL0 + 8'(4 * s), 32'(SRC_SW), r);
    repeat (4) @(posedge clk_i);
    chk(32'({sync_line_oe_o, sync_line_o}), 32'({6'h3f, LV}));
    wb_xfer(1'b0, OFS_SYNC_STAT, 32'h0, r);
    chk(r, 32'({6'h3f, 2'h0, LV}));
  endtask
  task automatic t_unmapped;
    logic [31:0] r;
    wb_xfer(1'b1, 8'h30, 32'hffffffff, r);
    wb_xfer(1'b0, 8'h30, 32'h0, r);
    chk(r, 32'h0);
    // byte lane 0 off: the select must keep its value
    wb_sel_i <= 4'he;
    wb_xfer(1'b1, OFS_CRANK0_SEL, 32'h05, r);
    wb_sel_i <= 4'hf;
    wb_xfer(1'b0, OFS_CRANK0_SEL, 32'h0, r);
    chk(r, 32'h0a);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_crank();
    t_sync();
    t_unmapped();
    report_and_stop();
  end
endmodule // tb_top
bind crank_sync_bus_router router_chk router_chk_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
  .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bp_crank_i, .slot_crank_i,
  .bp_sync_i, .slot_sync_i, .crank_bus_o, .crank_bus_oe_o, .sync_line_o, .sync_line_oe_o);
`default_nettype wire
